// *** hw/spc_ctrl.sv ***
// self-programming controller
`timescale 1ns/100ps

// What this block does
// RULE1: software reaches register at 0x57 only, not at 0x37
// RULE2: ready interrupt while enabled, global, store clear
// RULE3: concurrent-section erase/write sets busy, blocks reads
// RULE4: busy clears on re-enable or buffer load
// RULE5: signature arm: load reads signature, store inert
// RULE6: re-enable store reopens section, not while busy
// RULE7: re-enable during buffer load discards the buffer
// RULE8: lock-set store programs locks from low register
// RULE9: lock-set bit clears on completion or timeout
// RULE10: armed lock-set load returns lock or fuse
// RULE11: page-write store writes buffer to pointer page
// RULE12: page-write bit clears on completion or timeout
// RULE13: stall core during stalling-section erase/write
// RULE14: page-erase store erases page, bit auto-clears
// RULE15: store-enable alone fills buffer word from pair
// RULE16: four-cycle window; held high during erase/write
// RULE17: ignore illegal low five bit patterns
// RULE18: six lock bits only go toward zero, except chip erase sets all six back to one
// RULE19: lock byte layout, unused bits read one
// RULE20: lower lock bit blocks programming and fuses
// RULE21: both lock bits block verify and boot locks
// RULE22: page from pointer 14:7, word from 6:1
// RULE23: each operation takes the programming time
// RULE24: down-counter from write clears armed bits
module spc_ctrl #(
  parameter int PROG_CYCLES = spc_pkg::PROG_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   global_irq_flag,
  input  wire logic                   store_exec,
  input  wire logic                   load_exec,
  input  wire spc_pkg::spc_operand_s  operand,
  input  wire logic [7:0]             signature_byte,
  input  wire logic [7:0]             fuse_byte,
  input  wire logic                   chip_erase,
  output logic                        load_override,
  output logic      [7:0]             load_data,
  output logic                        ready_irq,
  output logic                        core_stall,
  output logic                        section_read_block,
  output spc_pkg::spc_flash_cmd_s     flash_cmd,
  output logic      [7:0]             memory_lock_byte,
  output spc_pkg::spc_protect_s       protect
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  spc_pkg::spc_state_e state;
  spc_pkg::spc_op_e    op;
  logic                program_ready_irq_enable;
  logic                section_busy_flag;
  logic [5:0]          cmd_bits;
  logic [2:0]          arm_cnt;
  logic [31:0]         prog_cnt;
  logic                buf_loaded;
  logic [5:0]          lock_bits;
  logic [7:0]          lock_pending;
  logic                op_concurrent;

  logic                ctrl_sel;
  logic                ctrl_wr;
  logic [4:0]          low5;
  logic                legal_pat;
  logic                sig_pat;
  logic                armed;
  logic                store_hit;
  logic                load_hit;
  logic                prog_done;
  logic [7:0]          z_page;
  logic                z_concurrent;
  logic [7:0]          ctrl_value;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_sel = 1'b0;
    if (reg_addr == spc_pkg::CTRL_DATA_ADDR) begin // RULE1
      ctrl_sel = 1'b1;
    end else if (reg_addr == spc_pkg::CTRL_IO_ADDR - spc_pkg::IO_DATA_OFFSET) begin
      ctrl_sel = 1'b0;
    end
  end

  assign ctrl_wr      = reg_wr && ctrl_sel;
  assign low5         = reg_wdata[4:0];
  assign legal_pat    = (low5 == spc_pkg::PAT_FILL) || (low5 == spc_pkg::PAT_ERASE) ||
                        (low5 == spc_pkg::PAT_WRITE) || (low5 == spc_pkg::PAT_LOCK) ||
                        (low5 == spc_pkg::PAT_REENABLE); // RULE17
  assign sig_pat      = reg_wdata[spc_pkg::BIT_SIG_RD] && (low5 == spc_pkg::PAT_FILL);
  assign armed        = (state == spc_pkg::SPC_ARMED);
  assign store_hit    = armed && store_exec;
  assign load_hit     = armed && load_exec && (arm_cnt >= spc_pkg::LPM_LAST_CNT);
  assign prog_done    = (state == spc_pkg::SPC_BUSY) && (prog_cnt == 32'h0000_0001);
  assign z_page       = operand.z_ptr[spc_pkg::PAGE_MSB:spc_pkg::PAGE_LSB]; // RULE22
  assign z_concurrent = (z_page < spc_pkg::FIRST_STALLING_SECTION_PG);
  assign ctrl_value   = {program_ready_irq_enable, section_busy_flag, cmd_bits};

  // ------------------------------------------------------------------
  // interrupt enable, written on any control write
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      program_ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      program_ready_irq_enable <= reg_wdata[spc_pkg::BIT_IRQ_EN];
    end
  end

  // ------------------------------------------------------------------
  // sequencer: arming window, command bits, programming timer
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state    <= spc_pkg::SPC_IDLE;
      op       <= spc_pkg::OP_NONE;
      cmd_bits <= 6'h00;
      arm_cnt  <= 3'h0;
      prog_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        spc_pkg::SPC_IDLE: begin
          // writes while armed or busy never arm
          if (ctrl_wr && (legal_pat || sig_pat)) begin
            cmd_bits <= reg_wdata[5:0];
            arm_cnt  <= spc_pkg::ARM_WINDOW; // RULE24
            state    <= spc_pkg::SPC_ARMED;
          end
        end
        spc_pkg::SPC_ARMED: begin
          if (store_hit) begin
            arm_cnt <= 3'h0;
            if (cmd_bits[spc_pkg::BIT_PG_ERASE] || cmd_bits[spc_pkg::BIT_PG_WRITE] ||
                cmd_bits[spc_pkg::BIT_LOCK_SET]) begin
              // op bits stay up until completion
              prog_cnt <= 32'(PROG_CYCLES); // RULE23
              state    <= spc_pkg::SPC_BUSY; // RULE16
              if (cmd_bits[spc_pkg::BIT_PG_ERASE]) begin
                op <= spc_pkg::OP_ERASE; // RULE14
              end else if (cmd_bits[spc_pkg::BIT_PG_WRITE]) begin
                op <= spc_pkg::OP_WRITE; // RULE11
              end else begin
                op <= spc_pkg::OP_LOCK; // RULE8
              end
            end else begin
              // other commands end with the store
              cmd_bits <= 6'h00; // RULE16
              state    <= spc_pkg::SPC_IDLE;
            end
          end else if (arm_cnt == 3'h1) begin
            cmd_bits <= 6'h00; // RULE9 RULE12 RULE14 RULE24
            arm_cnt  <= 3'h0;
            state    <= spc_pkg::SPC_IDLE;
          end else begin
            arm_cnt <= arm_cnt - 3'h1;
          end
        end
        spc_pkg::SPC_BUSY: begin
          prog_cnt <= prog_cnt - 32'h0000_0001;
          if (prog_done) begin
            cmd_bits <= 6'h00; // RULE9 RULE12 RULE14 RULE16
            op       <= spc_pkg::OP_NONE;
            state    <= spc_pkg::SPC_IDLE;
          end
        end
        default: begin
          state <= spc_pkg::SPC_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // concurrent-section busy flag and page-buffer bookkeeping
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      section_busy_flag <= 1'b0;
      op_concurrent     <= 1'b0;
    end else if (store_hit &&
                 (cmd_bits[spc_pkg::BIT_PG_ERASE] || cmd_bits[spc_pkg::BIT_PG_WRITE])) begin
      op_concurrent <= z_concurrent;
      if (z_concurrent) begin
        section_busy_flag <= 1'b1; // RULE3
      end
    end else if (store_hit && (cmd_bits[4:0] == spc_pkg::PAT_FILL) &&
                 !cmd_bits[spc_pkg::BIT_SIG_RD]) begin
      section_busy_flag <= 1'b0; // RULE4
    end else if (store_hit && cmd_bits[spc_pkg::BIT_REENABLE]) begin
      // armed only when idle, so never mid-operation
      section_busy_flag <= 1'b0; // RULE4 RULE6
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_loaded <= 1'b0;
    end else if (store_hit && (cmd_bits[4:0] == spc_pkg::PAT_FILL) &&
                 !cmd_bits[spc_pkg::BIT_SIG_RD]) begin
      buf_loaded <= 1'b1;
    end else if ((ctrl_wr && reg_wdata[spc_pkg::BIT_REENABLE]) ||
                 (store_hit && cmd_bits[spc_pkg::BIT_PG_WRITE])) begin
      buf_loaded <= 1'b0; // RULE7
    end
  end

  // ------------------------------------------------------------------
  // flash commands
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.buf_wr      <= 1'b0;
      flash_cmd.buf_discard <= 1'b0;
      flash_cmd.erase_start <= 1'b0;
      flash_cmd.write_start <= 1'b0;
      if (ctrl_wr && reg_wdata[spc_pkg::BIT_REENABLE] && buf_loaded) begin
        // aborts a fill even if the pattern is refused
        flash_cmd.buf_discard <= 1'b1; // RULE7
      end
      if (store_hit && (cmd_bits[4:0] == spc_pkg::PAT_FILL) &&
          !cmd_bits[spc_pkg::BIT_SIG_RD]) begin
        flash_cmd.buf_wr   <= 1'b1; // RULE15
        flash_cmd.buf_word <= operand.z_ptr[spc_pkg::WORD_MSB:spc_pkg::WORD_LSB]; // RULE22
        flash_cmd.buf_data <= operand.data_pair; // RULE15
      end
      if (store_hit && cmd_bits[spc_pkg::BIT_PG_ERASE]) begin
        flash_cmd.erase_start <= 1'b1; // RULE14
        flash_cmd.page        <= z_page; // RULE22
      end
      if (store_hit && cmd_bits[spc_pkg::BIT_PG_WRITE]) begin
        flash_cmd.write_start <= 1'b1; // RULE11
        flash_cmd.page        <= z_page; // RULE22
      end
    end
  end

  // ------------------------------------------------------------------
  // lock bits: captured at the store, committed at completion
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_pending <= 8'hFF;
    end else if (store_hit && cmd_bits[spc_pkg::BIT_LOCK_SET]) begin
      lock_pending <= operand.data_pair[7:0]; // RULE8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_bits <= spc_pkg::LOCK_RESET;
    end else if (chip_erase) begin
      lock_bits <= spc_pkg::LOCK_RESET; // RULE18
    end else if (prog_done && (op == spc_pkg::OP_LOCK)) begin
      lock_bits <= lock_bits & lock_pending[5:0]; // RULE18
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memory_lock_byte <= {spc_pkg::LOCK_UNUSED, spc_pkg::LOCK_RESET};
      protect          <= '0;
    end else begin
      memory_lock_byte       <= {spc_pkg::LOCK_UNUSED, lock_bits}; // RULE19
      // bit 0 programmed alone is mode 2; both programmed is mode 3
      protect.prog_block     <= !lock_bits[0] || !lock_bits[1]; // RULE20 RULE21
      protect.fuse_lock      <= !lock_bits[0] || !lock_bits[1]; // RULE20 RULE21
      protect.verify_block   <= !lock_bits[0] && !lock_bits[1]; // RULE21
      protect.boot_lock_lock <= !lock_bits[0] && !lock_bits[1]; // RULE21
    end
  end

  // ------------------------------------------------------------------
  // program-memory loads redirected by an armed command
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_override <= 1'b0;
      load_data     <= 8'h00;
    end else begin
      load_override <= 1'b0;
      if (load_hit && cmd_bits[spc_pkg::BIT_SIG_RD]) begin
        load_override <= 1'b1;
        load_data     <= signature_byte; // RULE5
      end else if (load_hit && cmd_bits[spc_pkg::BIT_LOCK_SET]) begin
        load_override <= 1'b1;
        load_data     <= operand.z_ptr[0] ? fuse_byte :
                         {spc_pkg::LOCK_UNUSED, lock_bits}; // RULE10
      end
    end
  end

  // ------------------------------------------------------------------
  // core-facing status
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_irq          <= 1'b0;
      core_stall         <= 1'b0;
      section_read_block <= 1'b0;
    end else begin
      ready_irq <= program_ready_irq_enable && global_irq_flag &&
                   !cmd_bits[spc_pkg::BIT_STORE_EN]; // RULE2
      // stall drops at the same edge as completion
      core_stall <= (state == spc_pkg::SPC_BUSY) && !prog_done &&
                    ((op == spc_pkg::OP_ERASE) || (op == spc_pkg::OP_WRITE)) &&
                    !op_concurrent; // RULE13
      section_read_block <= section_busy_flag; // RULE3
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= spc_pkg::CTRL_RESET;
    end else if (reg_rd && ctrl_sel) begin
      reg_rdata <= ctrl_value;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : spc_ctrl

// *** hw/spc_pkg.sv ***
// constants and types for the self-programming controller
package spc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_DATA_ADDR  = 8'h57;
  localparam logic [7:0] CTRL_IO_ADDR   = 8'h37;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_SIG_RD   = 5;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_LOCK_SET = 3;
  localparam int BIT_PG_WRITE = 2;
  localparam int BIT_PG_ERASE = 1;
  localparam int BIT_STORE_EN = 0;

  // legal patterns of the low five control bits
  localparam logic [4:0] PAT_FILL     = 5'h01;
  localparam logic [4:0] PAT_ERASE    = 5'h03;
  localparam logic [4:0] PAT_WRITE    = 5'h05;
  localparam logic [4:0] PAT_LOCK     = 5'h09;
  localparam logic [4:0] PAT_REENABLE = 5'h11;

  // ------------------------------------------------------------------
  // lock byte and flash geometry
  // ------------------------------------------------------------------
  localparam logic [5:0] LOCK_RESET     = 6'h3F;
  localparam logic [1:0] LOCK_UNUSED    = 2'h3;
  localparam logic [7:0] FIRST_STALLING_SECTION_PG  = 8'hE0;
  localparam int         PAGE_MSB       = 14;
  localparam int         PAGE_LSB       = 7;
  localparam int         WORD_MSB       = 6;
  localparam int         WORD_LSB       = 1;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam logic [2:0] ARM_WINDOW     = 3'h4;
  localparam logic [2:0] LPM_LAST_CNT   = 3'h2;
  localparam int         PROG_CYCLES    = 320000;
  localparam int         PROG_MAX_CYC   = 340000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_IDLE  = 2'b00,
    SPC_ARMED = 2'b01,
    SPC_BUSY  = 2'b10
  } spc_state_e;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK  = 2'b11
  } spc_op_e;

  // operands of a store or load instruction
  typedef struct packed {
    logic [15:0] z_ptr;
    logic [15:0] data_pair;
  } spc_operand_s;

  // commands to flash array and page buffer
  typedef struct packed {
    logic        buf_wr;
    logic [5:0]  buf_word;
    logic [15:0] buf_data;
    logic        buf_discard;
    logic        erase_start;
    logic        write_start;
    logic [7:0]  page;
  } spc_flash_cmd_s;

  // protection from the memory lock bits
  typedef struct packed {
    logic prog_block;
    logic verify_block;
    logic fuse_lock;
    logic boot_lock_lock;
  } spc_protect_s;

endpackage : spc_pkg

// *** tb/spc_core_model.sv ***
// core model: register access and store/load instructions
`timescale 1ns/100ps
module spc_core_model (
  input  wire logic                  ref_clk,
  input  wire logic [7:0]            reg_rdata,
  output logic                       reg_wr,
  output logic                       reg_rd,
  output logic [7:0]                 reg_addr,
  output logic [7:0]                 reg_wdata,
  output logic                       store_exec,
  output logic                       load_exec,
  output spc_pkg::spc_operand_s      operand
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    store_exec = 1'b0;
    load_exec = 1'b0;
    operand = '0;
  end

  // calls start and end just after an edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    data = reg_rdata;
  endtask : rd

  // released operands inverted so stale ones fail
  task automatic instr(input logic is_load, input logic [15:0] z, input logic [15:0] d);
    operand = {z, d};
    load_exec = is_load;
    store_exec = !is_load;
    @(posedge ref_clk);
    #1;
    store_exec = 1'b0;
    load_exec = 1'b0;
    operand = ~operand;
  endtask : instr
endmodule : spc_core_model

// *** tb/spc_ctrl_properties.sv ***
// port checks of the self-programming controller
`timescale 1ns/100ps
module spc_ctrl_properties #(
  parameter int PROG_CYCLES = spc_pkg::PROG_CYCLES
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    global_irq_flag,
  input wire logic                    store_exec,
  input wire logic                    load_exec,
  input wire spc_pkg::spc_operand_s   operand,
  input wire logic                    chip_erase,
  input wire logic                    load_override,
  input wire logic                    ready_irq,
  input wire logic                    core_stall,
  input wire logic                    section_read_block,
  input wire spc_pkg::spc_flash_cmd_s flash_cmd,
  input wire logic [7:0]              memory_lock_byte,
  input wire spc_pkg::spc_protect_s   protect
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  int stall_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst || !core_stall) begin
      stall_cnt <= 0;
    end else begin
      stall_cnt <= stall_cnt + 1;
    end
  end

  sequence s_rww_start;
    (flash_cmd.erase_start || flash_cmd.write_start) && flash_cmd.page < spc_pkg::FIRST_STALLING_SECTION_PG;
  endsequence
  sequence s_stalling_section_start;
    (flash_cmd.erase_start || flash_cmd.write_start) && flash_cmd.page >= spc_pkg::FIRST_STALLING_SECTION_PG;
  endsequence
  sequence s_lock_steady;
    $stable(memory_lock_byte) ##1 $stable(memory_lock_byte);
  endsequence

  property p_fill;
    flash_cmd.buf_wr |-> $past(store_exec) && flash_cmd.buf_data == $past(operand.data_pair)
      && flash_cmd.buf_word == $past(operand.z_ptr[6:1]);
  endproperty
  a_fill: assert property (p_fill) else $error("fill differs from store");
  property p_page;
    flash_cmd.erase_start || flash_cmd.write_start |-> $past(store_exec)
      && flash_cmd.page == $past(operand.z_ptr[14:7]);
  endproperty
  a_page: assert property (p_page) else $error("page differs from store");
  property p_load;
    load_override |-> $past(load_exec);
  endproperty
  a_load: assert property (p_load) else $error("override without load");
  property p_irq;
    ready_irq |-> $past(global_irq_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("ready without global");
  property p_busy;
    s_rww_start |-> ##[0:2] section_read_block;
  endproperty
  a_busy: assert property (p_busy) else $error("section not blocked");
  property p_stall;
    s_stalling_section_start |-> ##[0:1] core_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled");
  property p_stall_len;
    $fell(core_stall) |-> stall_cnt >= PROG_CYCLES - 2 && stall_cnt <= PROG_CYCLES + 2;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_lock_down;
    !($past(chip_erase) || $past(chip_erase, 2) || $past(chip_erase, 3))
      |-> (memory_lock_byte & ~$past(memory_lock_byte)) == 8'h00;
  endproperty
  a_lock_down: assert property (p_lock_down) else $error("lock bit went to one");
  property p_lock_top;
    memory_lock_byte[7:6] == spc_pkg::LOCK_UNUSED;
  endproperty
  a_lock_top: assert property (p_lock_top) else $error("unused lock bits not one");
  property p_prot_prog;
    s_lock_steady |-> protect.prog_block == !(&memory_lock_byte[1:0]);
  endproperty
  a_prot_prog: assert property (p_prot_prog) else $error("program block wrong");
  property p_prot_verify;
    s_lock_steady |-> protect.verify_block == !(|memory_lock_byte[1:0]);
  endproperty
  a_prot_verify: assert property (p_prot_verify) else $error("verify block wrong");
endmodule : spc_ctrl_properties

bind spc_ctrl spc_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) u_spc_ctrl_properties (
  .ref_clk(ref_clk), .rst(rst), .global_irq_flag(global_irq_flag), .store_exec(store_exec),
  .load_exec(load_exec), .operand(operand), .chip_erase(chip_erase),
  .load_override(load_override), .ready_irq(ready_irq), .core_stall(core_stall),
  .section_read_block(section_read_block), .flash_cmd(flash_cmd),
  .memory_lock_byte(memory_lock_byte), .protect(protect));

// *** tb/spc_ctrl_tb.sv ***
// testbench for the self-programming controller
`timescale 1ns/100ps
module spc_ctrl_tb;
  localparam logic [7:0] A = spc_pkg::CTRL_DATA_ADDR;
  logic                    ref_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    global_irq_flag = 1'b0;
  logic                    chip_erase = 1'b0;
  logic                    reg_wr, reg_rd, store_exec, load_exec, load_override;
  logic                    ready_irq, core_stall, section_read_block;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata, load_data, memory_lock_byte, rd_val;
  logic [7:0]              bad [4] = '{8'h07, 8'h02, 8'h18, 8'h1F};
  spc_pkg::spc_operand_s   operand;
  spc_pkg::spc_flash_cmd_s flash_cmd;
  spc_pkg::spc_protect_s   protect;
  logic                    discard_seen = 1'b0;
  int                      fail_count = 0;
  int                      checks = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (flash_cmd.buf_discard) discard_seen <= 1'b1;

  spc_ctrl #(.PROG_CYCLES(20)) u_spc_ctrl (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_flag(global_irq_flag),
    .store_exec(store_exec), .load_exec(load_exec), .operand(operand),
    .signature_byte(8'h3B), .fuse_byte(8'h5C), .chip_erase(chip_erase),
    .load_override(load_override), .load_data(load_data), .ready_irq(ready_irq),
    .core_stall(core_stall), .section_read_block(section_read_block),
    .flash_cmd(flash_cmd), .memory_lock_byte(memory_lock_byte), .protect(protect));

  spc_core_model u_spc_core_model (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .store_exec(store_exec),
    .load_exec(load_exec), .operand(operand));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic w(input logic [7:0] d);
    u_spc_core_model.wr(A, d);
  endtask : w
  task automatic r(input logic [7:0] a);
    u_spc_core_model.rd(a, rd_val);
  endtask : r
  task automatic spm(input logic [15:0] z, input logic [15:0] d);
    u_spc_core_model.instr(1'b0, z, d);
  endtask : spm
  task automatic lpm(input logic [15:0] z);
    u_spc_core_model.instr(1'b1, z, 16'h0000);
  endtask : lpm
  // bounded poll: a stuck op fails, not hangs
  task automatic wait_done();
    for (int i = 0; i < 60; i++) begin
      r(A);
      if (rd_val[0] === 1'b0) break;
    end
  endtask : wait_done

  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    r(A);
    chk("ctrl reset", rd_val, spc_pkg::CTRL_RESET);
    chk("lock byte reset", memory_lock_byte, 8'hFF);
    chk("no protection", protect, 4'h0);
    r(8'h37);
    chk("io offset unmapped", rd_val, 8'h00);
    w(8'h01);
    spm(16'h0087, 16'hA55A);
    chk("fill strobe", flash_cmd.buf_wr, 1'b1);
    chk("fill word", flash_cmd.buf_word, 6'h03);
    chk("fill data", flash_cmd.buf_data, 16'hA55A);
    r(A);
    chk("store enable cleared", rd_val, 8'h00);
    w(8'h05);
    r(A);
    chk("write armed", rd_val, 8'h05);
    tick(3);
    r(A);
    chk("write timed out", rd_val, 8'h00);
    spm(16'h0000, 16'h0000);
    chk("late store", flash_cmd.write_start, 1'b0);
    foreach (bad[i]) begin
      w(bad[i]);
      r(A);
      chk("illegal pattern", rd_val, 8'h00);
    end
    global_irq_flag = 1'b1;
    w(8'hC0);
    r(A);
    chk("busy bit not writable", rd_val, 8'h80);
    chk("ready when idle", ready_irq, 1'b1);
    w(8'h81);
    tick(1);
    chk("no ready while armed", ready_irq, 1'b0);
    tick(4);
    chk("ready after expiry", ready_irq, 1'b1);
    global_irq_flag = 1'b0;
    tick(2);
    chk("ready needs global", ready_irq, 1'b0);
    w(8'h00);
    w(8'h03);
    spm(16'h0800, 16'h1234);
    chk("erase strobe", flash_cmd.erase_start, 1'b1);
    chk("erase page", flash_cmd.page, 8'h10);
    tick(1);
    chk("section blocked", section_read_block, 1'b1);
    r(A);
    chk("erase in progress", rd_val, 8'h43);
    w(8'h11);
    spm(16'h0000, 16'h0000);
    tick(1);
    chk("no reenable while busy", section_read_block, 1'b1);
    wait_done();
    chk("busy after erase", rd_val, 8'h40);
    w(8'h11);
    spm(16'h0000, 16'h0000);
    tick(1);
    chk("section reopened", section_read_block, 1'b0);
    for (int i = 0; i < 2; i++) begin
      w(i ? 8'h05 : 8'h03);
      spm({1'b0, 8'hE0 + 8'(i), 7'h00}, 16'h0000);
      chk("stall page start", flash_cmd.erase_start | flash_cmd.write_start, 1'b1);
      tick(1);
      chk("core stalled", core_stall, 1'b1);
      chk("no section block", section_read_block, 1'b0);
      for (int j = 0; j < 60 && core_stall !== 1'b0; j++) tick(1);
      tick(2);
      r(A);
      chk("stall op done", rd_val, 8'h00);
    end
    w(8'h09);
    lpm(16'h0000);
    chk("lock override", load_override, 1'b1);
    chk("lock read", load_data, 8'hFF);
    spm(16'hFFFF, 16'hAAFE);
    wait_done();
    tick(2);
    chk("lock a set", memory_lock_byte, 8'hFE);
    chk("single lock mode", protect, 4'hA);
    w(8'h09);
    lpm(16'h0001);
    chk("fuse read", load_data, 8'h5C);
    spm(16'h0000, 16'h00FD);
    wait_done();
    tick(2);
    chk("lock only toward zero", memory_lock_byte, 8'hFC);
    chk("double lock mode", protect, 4'hF);
    chip_erase = 1'b1;
    tick(1);
    chip_erase = 1'b0;
    tick(3);
    chk("chip erase unlocks", memory_lock_byte, 8'hFF);
    w(8'h21);
    lpm(16'h0000);
    chk("signature read", load_data, 8'h3B);
    spm(16'h0800, 16'h0000);
    chk("signature store inert", {flash_cmd.buf_wr, flash_cmd.erase_start}, 2'b00);
    w(8'h03);
    spm(16'h1000, 16'h0000);
    wait_done();
    w(8'h01);
    spm(16'h0002, 16'h1111);
    r(A);
    chk("fill clears busy", rd_val, 8'h00);
    discard_seen = 1'b0;
    w(8'h11);
    tick(2);
    chk("load aborted", discard_seen, 1'b1);
    results();
  end
endmodule : spc_ctrl_tb
